// ===== rwiu_top.v
// Watchdog, interrupt combiner and event flags behind an SRAM-style bus.
// Assumes all pins are synchronous to CLK_I and the clock counters supply
// BCD time with an update pulse.
//
// How it works
// - Low two watchdog bits pick time-out resolution
// - Time-out equals five-bit multiplier times resolution
// - Zero multiplier disables the watchdog entirely
// - Steered time-out pulses reset, clears watchdog register
// - Unsteered time-out holds interrupt until rewrite/power-fail
// - Every time-out sets the watchdog flag
// - Any watchdog write restarts the time-out period
// - Power failure disables watchdog; software re-arms it
// - Event flags drive interrupt only when enabled
// - Flags read clears all flags, releases flag interrupts only
// - Clear needs flags address held 50 ns
// - Rate field selects periodic interval or none
// - Alarm flag set when compared time fields match
// - Alarm bit 7 masks its field from compare
// - Backup mode drives interrupt only for enabled alarm
// - Alarm enable cleared at power-on, flag keeps updating
// - Supply fail sets flag, warns, then resets
// - Power-up clears supply-fail interrupt enable
// - Power-up battery check sets battery-low flag
// - All interrupt enables cleared at power-up
`timescale 1ns/1ps
`include "rwiu_map.vh"

module rwiu_top #(
    parameter [31:0] CLK_HZ = 32'd100000000,
    parameter [31:0] OSC_HZ = `RWIU_OSC_HZ,
    parameter [31:0] RST_PULSE_CYC = 32'd20000000,
    parameter [31:0] WARN_CYC = 32'd10000
) (
    // Clock and reset
    input wire CLK_I,
    input wire RST_N_I,
    // Processor bus
    input wire [14:0] A_I,
    input wire CE_N_I,
    input wire OE_N_I,
    input wire WE_N_I,
    input wire [7:0] DQ_I,
    output reg [7:0] DQ_O,
    output reg DQ_OE_O,
    // Clock counters
    input wire [7:0] TIME_SEC_I,
    input wire [7:0] TIME_MIN_I,
    input wire [7:0] TIME_HOUR_I,
    input wire [7:0] TIME_DATE_I,
    input wire TIME_UPDATE_I,
    // Supply monitor
    input wire SUPPLY_FAIL_I,
    input wire BATTERY_LOW_I,
    // Open-drain outputs and chip deselect
    output reg INT_O,
    output reg INT_OE_O,
    output reg RST_O,
    output reg RST_OE_O,
    output reg DESELECT_O
);

// ----------------------------------------------------------------
// Constants and helpers
// ----------------------------------------------------------------
localparam integer STABLE_RAW = (`RWIU_STABLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
localparam integer STABLE_INT = (STABLE_RAW < 1) ? 1 : STABLE_RAW;
localparam [7:0] STABLE_CYC = STABLE_INT[7:0];

// Ticks in one resolution unit
function [16:0] res_len;
    input [1:0] res;
    begin
        case (res)
            2'h0: res_len = `RWIU_RES_16TH;
            2'h1: res_len = `RWIU_RES_QUARTER;
            2'h2: res_len = `RWIU_RES_ONE;
            default: res_len = `RWIU_RES_FOUR;
        endcase
    end
endfunction

function is_mapped;
    input [14:0] a;
    begin
        is_mapped = (a == `RWIU_ADDR_FLAGS) || ((a >= `RWIU_ADDR_ALM_SEC) && (a <= `RWIU_ADDR_WDOG));
    end
endfunction

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
reg [14:0] a_d_r;
reg [7:0] dq_d_r;
reg ce_n_d_r;
reg we_n_d_r;
reg pf_d_r;
reg [7:0] wd_r;
reg [7:0] irq_r;
reg [7:0] alm_sec_r;
reg [7:0] alm_min_r;
reg [7:0] alm_hour_r;
reg [7:0] alm_date_r;
reg [7:0] flags_r;
reg [7:0] flags_nxt;
reg [7:0] stab_r;
reg [16:0] unit_r;
reg [4:0] mult_cnt_r;
reg wd_int_r;
reg [31:0] rst_cnt_r;
reg [31:0] warn_cnt_r;
reg bl_chk_r;
wire tick;
wire periodic;
wire alarm_hit;

wire [4:0] mult = wd_r[`RWIU_WD_MULT_HI:`RWIU_WD_MULT_LO];
wire [16:0] unit_len = res_len(wd_r[`RWIU_WD_RES_HI:`RWIU_WD_RES_LO]);
wire pf_rise = SUPPLY_FAIL_I & ~pf_d_r;
wire pf_fall = ~SUPPLY_FAIL_I & pf_d_r;

// ----------------------------------------------------------------
// Bus access
// ----------------------------------------------------------------
// A write is taken at the rising edge of write enable, with the address
// and data seen in the last cycle of the strobe
wire wr_stb = ~DESELECT_O & WE_N_I & ~we_n_d_r & ~ce_n_d_r;
wire wr_wd = wr_stb & (a_d_r == `RWIU_ADDR_WDOG);
wire rd_act = ~DESELECT_O & ~CE_N_I & ~OE_N_I & WE_N_I;
wire rd_flags = rd_act & (A_I == `RWIU_ADDR_FLAGS);
wire flag_clr = rd_flags & (stab_r == STABLE_CYC - 8'h01);

// Pin samples for edge detection
always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        a_d_r <= 15'h0000;
        dq_d_r <= 8'h00;
        ce_n_d_r <= 1'b1;
        we_n_d_r <= 1'b1;
        pf_d_r <= 1'b0;
    end else begin
        a_d_r <= A_I;
        dq_d_r <= DQ_I;
        ce_n_d_r <= CE_N_I;
        we_n_d_r <= WE_N_I;
        pf_d_r <= SUPPLY_FAIL_I;
    end
end

// Stability counter: a glitching address never clears the flags
always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        stab_r <= 8'h00;
    end else if (!rd_flags) begin
        stab_r <= 8'h00;
    end else if (stab_r != STABLE_CYC) begin
        stab_r <= stab_r + 8'h01;
    end
end

// Read data; frozen once a flags read has started so the value read is
// the one before the clear
always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        DQ_O <= 8'h00;
        DQ_OE_O <= 1'b0;
    end else begin
        DQ_OE_O <= rd_act & is_mapped(A_I);
        if (stab_r == 8'h00) begin
            case (A_I)
                `RWIU_ADDR_FLAGS: DQ_O <= flags_r;
                `RWIU_ADDR_ALM_SEC: DQ_O <= alm_sec_r;
                `RWIU_ADDR_ALM_MIN: DQ_O <= alm_min_r;
                `RWIU_ADDR_ALM_HOUR: DQ_O <= alm_hour_r;
                `RWIU_ADDR_ALM_DATE: DQ_O <= alm_date_r;
                `RWIU_ADDR_IRQ: DQ_O <= irq_r;
                `RWIU_ADDR_WDOG: DQ_O <= wd_r;
                default: DQ_O <= 8'h00;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// Writable registers
// ----------------------------------------------------------------
// Interrupts and alarm registers; enables drop on every power-up
always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        irq_r <= `RWIU_REG_RST;
        alm_sec_r <= `RWIU_REG_RST;
        alm_min_r <= `RWIU_REG_RST;
        alm_hour_r <= `RWIU_REG_RST;
        alm_date_r <= `RWIU_REG_RST;
    end else if (pf_fall) begin
        irq_r[`RWIU_IRQ_AIE] <= 1'b0;
        irq_r[`RWIU_IRQ_SUPPLY_FAIL_IRQ_ENABLE] <= 1'b0;
        irq_r[`RWIU_IRQ_ABE] <= 1'b0;
        irq_r[`RWIU_IRQ_PIE] <= 1'b0;
    end else if (wr_stb) begin
        case (a_d_r)
            `RWIU_ADDR_IRQ: irq_r <= dq_d_r;
            `RWIU_ADDR_ALM_SEC: alm_sec_r <= dq_d_r;
            `RWIU_ADDR_ALM_MIN: alm_min_r <= dq_d_r;
            `RWIU_ADDR_ALM_HOUR: alm_hour_r <= dq_d_r;
            `RWIU_ADDR_ALM_DATE: alm_date_r <= dq_d_r;
            default: irq_r <= irq_r;
        endcase
    end
end

// ----------------------------------------------------------------
// Watchdog
// ----------------------------------------------------------------
wire unit_end = tick & (unit_r == unit_len - 17'h00001);
wire wd_to = ~wr_wd & (mult != 5'h00) & unit_end & (mult_cnt_r + 5'h01 == mult);

// Period counters restart on every watchdog write
always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        unit_r <= 17'h00000;
        mult_cnt_r <= 5'h00;
    end else if (wr_wd || mult == 5'h00 || wd_to) begin
        unit_r <= 17'h00000;
        mult_cnt_r <= 5'h00;
    end else if (tick) begin
        unit_r <= unit_end ? 17'h00000 : unit_r + 17'h00001;
        mult_cnt_r <= unit_end ? mult_cnt_r + 5'h01 : mult_cnt_r;
    end
end

// Watchdog register and the steered outcome of a time-out
always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        wd_r <= `RWIU_REG_RST;
        wd_int_r <= 1'b0;
    end else if (pf_rise) begin
        wd_r <= `RWIU_REG_RST;
        wd_int_r <= 1'b0;
    end else if (wr_wd) begin
        wd_r <= dq_d_r;
        wd_int_r <= 1'b0;
    end else if (wd_to && wd_r[`RWIU_WD_STEER]) begin
        wd_r <= `RWIU_REG_RST;
    end else if (wd_to) begin
        wd_int_r <= 1'b1;
    end
end

// ----------------------------------------------------------------
// Reset pulse, power-fail warning and deselect
// ----------------------------------------------------------------
// The warning counter runs down from each supply-fail rise, even if the supply recovers
always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        rst_cnt_r <= 32'h00000000;
        warn_cnt_r <= 32'h00000000;
        DESELECT_O <= 1'b0;
    end else begin
        if (pf_rise)
            warn_cnt_r <= WARN_CYC;
        else if (warn_cnt_r != 32'h00000000)
            warn_cnt_r <= warn_cnt_r - 32'h00000001;
        DESELECT_O <= SUPPLY_FAIL_I & ~pf_rise & (warn_cnt_r == 32'h00000000);
        if ((wd_to && wd_r[`RWIU_WD_STEER]) || pf_fall)
            rst_cnt_r <= RST_PULSE_CYC;
        else if (rst_cnt_r != 32'h00000000)
            rst_cnt_r <= rst_cnt_r - 32'h00000001;
    end
end

// ----------------------------------------------------------------
// Flags
// ----------------------------------------------------------------
// A hardware set in the clearing cycle survives the clear
always @* begin
    flags_nxt = flag_clr ? 8'h00 : flags_r;
    if (wd_to)
        flags_nxt[`RWIU_FLG_WDF] = 1'b1;
    if (alarm_hit)
        flags_nxt[`RWIU_FLG_AF] = 1'b1;
    if (pf_rise)
        flags_nxt[`RWIU_FLG_SUPPLY_FAIL_FLAG] = 1'b1;
    if (periodic)
        flags_nxt[`RWIU_FLG_PF] = 1'b1;
    if (bl_chk_r && BATTERY_LOW_I)
        flags_nxt[`RWIU_FLG_BLF] = 1'b1;
end

// Battery check armed after reset release and after each power-up
always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        flags_r <= 8'h00;
        bl_chk_r <= 1'b1;
    end else begin
        flags_r <= flags_nxt;
        bl_chk_r <= pf_fall;
    end
end

// ----------------------------------------------------------------
// Interrupt and reset pins
// ----------------------------------------------------------------
// During backup only an enabled alarm may pull the line
wire irq_live = wd_int_r | (flags_r[`RWIU_FLG_PF] & irq_r[`RWIU_IRQ_PIE]) |
                (flags_r[`RWIU_FLG_AF] & irq_r[`RWIU_IRQ_AIE]) |
                (flags_r[`RWIU_FLG_SUPPLY_FAIL_FLAG] & irq_r[`RWIU_IRQ_SUPPLY_FAIL_IRQ_ENABLE]);
wire irq_bak = irq_r[`RWIU_IRQ_ABE] & irq_r[`RWIU_IRQ_AIE] & flags_r[`RWIU_FLG_AF];

always @(posedge CLK_I) begin
    if (!RST_N_I) begin
        INT_O <= 1'b0;
        INT_OE_O <= 1'b0;
        RST_O <= 1'b0;
        RST_OE_O <= 1'b0;
    end else begin
        INT_O <= 1'b0;
        INT_OE_O <= DESELECT_O ? irq_bak : irq_live;
        RST_O <= 1'b0;
        RST_OE_O <= (rst_cnt_r != 32'h00000000) | DESELECT_O;
    end
end

// ----------------------------------------------------------------
// Timebase and alarm
// ----------------------------------------------------------------
rwiu_timebase #(
    .CLK_HZ(CLK_HZ),
    .OSC_HZ(OSC_HZ)
) u_timebase (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .rate_i(irq_r[`RWIU_IRQ_RATE_HI:`RWIU_IRQ_RATE_LO]),
    .tick_o(tick),
    .periodic_o(periodic)
);

rwiu_alarm_match u_alarm (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .alm_sec_i(alm_sec_r),
    .alm_min_i(alm_min_r),
    .alm_hour_i(alm_hour_r),
    .alm_date_i(alm_date_r),
    .sec_i(TIME_SEC_I),
    .min_i(TIME_MIN_I),
    .hour_i(TIME_HOUR_I),
    .date_i(TIME_DATE_I),
    .update_i(TIME_UPDATE_I),
    .match_o(alarm_hit)
);

endmodule

// ===== rwiu_map.vh
// Address map, field positions, reset values and timebase counts of the
// watchdog and interrupt unit.
// Assumes a 15-bit byte address bus and a 32768 Hz oscillator tick.
`ifndef RWIU_MAP_VH
`define RWIU_MAP_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define RWIU_ADDR_FLAGS 15'h7ff0
`define RWIU_ADDR_ALM_SEC 15'h7ff2
`define RWIU_ADDR_ALM_MIN 15'h7ff3
`define RWIU_ADDR_ALM_HOUR 15'h7ff4
`define RWIU_ADDR_ALM_DATE 15'h7ff5
`define RWIU_ADDR_IRQ 15'h7ff6
`define RWIU_ADDR_WDOG 15'h7ff7
`define RWIU_REG_RST 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RWIU_WD_STEER 7
`define RWIU_WD_MULT_HI 6
`define RWIU_WD_MULT_LO 2
`define RWIU_WD_RES_HI 1
`define RWIU_WD_RES_LO 0
`define RWIU_IRQ_AIE 7
`define RWIU_IRQ_SUPPLY_FAIL_IRQ_ENABLE 6
`define RWIU_IRQ_ABE 5
`define RWIU_IRQ_PIE 4
`define RWIU_IRQ_RATE_HI 3
`define RWIU_IRQ_RATE_LO 0
`define RWIU_FLG_WDF 7
`define RWIU_FLG_AF 6
`define RWIU_FLG_SUPPLY_FAIL_FLAG 5
`define RWIU_FLG_BLF 4
`define RWIU_FLG_PF 3
`define RWIU_ALM_MASK 7

// ----------------------------------------------------------------
// Timebase, in oscillator ticks unless noted
// ----------------------------------------------------------------
`define RWIU_OSC_HZ 32768
`define RWIU_RES_16TH 17'h00800
`define RWIU_RES_QUARTER 17'h02000
`define RWIU_RES_ONE 17'h08000
`define RWIU_RES_FOUR 17'h20000
`define RWIU_RATE_NONE 4'h0
`define RWIU_RATE_10MS 4'h1
`define RWIU_RATE_100MS 4'h2
`define RWIU_P10MS_TICKS 12'h148
`define RWIU_P100MS_TICKS 12'hccd
`define RWIU_STABLE_NS 50

`endif

// ===== rwiu_timebase.v
// Oscillator tick generator, prescaler chain and periodic event source.
// Assumes CLK_HZ is above OSC_HZ; the tick is a one-cycle pulse.
`timescale 1ns/1ps
`include "rwiu_map.vh"

module rwiu_timebase #(
    parameter [31:0] CLK_HZ = 32'd100000000,
    parameter [31:0] OSC_HZ = `RWIU_OSC_HZ
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Periodic rate select
    input wire [3:0] rate_i,
    // Events
    output reg tick_o,
    output reg periodic_o
);

// ----------------------------------------------------------------
// Fractional divider
// ----------------------------------------------------------------
reg [31:0] acc_r;
reg [13:0] pre_r;
reg [11:0] dec_r;
wire [31:0] acc_sum = acc_r + OSC_HZ;
wire wrap = (acc_sum >= CLK_HZ);

// Binary prefix mask of a power-of-two rate code
function [13:0] rate_mask;
    input [3:0] code;
    begin
        rate_mask = (14'h0001 << (code - 4'h1)) - 14'h0001;
    end
endfunction

wire [13:0] mask = rate_mask(rate_i);
wire [11:0] dec_len = (rate_i == `RWIU_RATE_10MS) ? `RWIU_P10MS_TICKS : `RWIU_P100MS_TICKS;
wire dec_mode = (rate_i == `RWIU_RATE_10MS) || (rate_i == `RWIU_RATE_100MS);

// Exact average rate; jitter of one clock per tick is harmless here
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        acc_r <= 32'h00000000;
        tick_o <= 1'b0;
    end else begin
        acc_r <= wrap ? acc_sum - CLK_HZ : acc_sum;
        tick_o <= wrap;
    end
end

// Prescaler taps and the two decimal rates
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        pre_r <= 14'h0000;
        dec_r <= 12'h000;
        periodic_o <= 1'b0;
    end else begin
        periodic_o <= 1'b0;
        if (tick_o) begin
            pre_r <= pre_r + 14'h0001;
            dec_r <= (dec_r == dec_len - 12'h001) ? 12'h000 : dec_r + 12'h001;
            if (dec_mode) begin
                periodic_o <= (dec_r == dec_len - 12'h001);
            end else if (rate_i != `RWIU_RATE_NONE) begin
                periodic_o <= ((pre_r & mask) == mask);
            end
        end
    end
end

endmodule

// ===== rwiu_alarm_match.v
// Alarm comparator: four masked BCD fields against the running clock.
// Assumes update_i pulses once per clock update with time fields settled.
`timescale 1ns/1ps
`include "rwiu_map.vh"

module rwiu_alarm_match (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Alarm settings and current time
    input wire [7:0] alm_sec_i,
    input wire [7:0] alm_min_i,
    input wire [7:0] alm_hour_i,
    input wire [7:0] alm_date_i,
    input wire [7:0] sec_i,
    input wire [7:0] min_i,
    input wire [7:0] hour_i,
    input wire [7:0] date_i,
    input wire update_i,
    // Match event
    output reg match_o
);

// ----------------------------------------------------------------
// Field compare
// ----------------------------------------------------------------
// Hours and date keep an unused bit 6, so only six bits are compared there
function fld_ok;
    input [7:0] alm;
    input [7:0] now;
    input wide;
    begin
        if (alm[`RWIU_ALM_MASK])
            fld_ok = 1'b1;
        else if (wide)
            fld_ok = (alm[6:0] == now[6:0]);
        else
            fld_ok = (alm[5:0] == now[5:0]);
    end
endfunction

wire all_ok = fld_ok(alm_sec_i, sec_i, 1'b1) & fld_ok(alm_min_i, min_i, 1'b1) &
              fld_ok(alm_hour_i, hour_i, 1'b0) & fld_ok(alm_date_i, date_i, 1'b0);

// Checked once per update cycle only
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        match_o <= 1'b0;
    end else begin
        match_o <= update_i & all_ok;
    end
end

endmodule

// ===== rwiu_cpu_model.sv
// Processor model on the SRAM-style bus of the watchdog unit.
// Assumes the unit registers read data one cycle after the address.
`timescale 1ns/1ps

module rwiu_cpu_model (
    // Clock
    input wire clk_i,
    // Bus toward the unit
    output reg [14:0] a_o,
    output reg ce_n_o,
    output reg oe_n_o,
    output reg we_n_o,
    output reg [7:0] dq_o,
    // Read data from the unit
    input wire [7:0] dq_i,
    input wire dq_oe_i
);
    // Idle bus; released data shows the inverse of the last byte
    initial begin
        a_o <= 15'h0000;
        ce_n_o <= 1'b1;
        oe_n_o <= 1'b1;
        we_n_o <= 1'b1;
        dq_o <= 8'h00;
    end

    // Write: everything held until the edge after the strobe rises
    task wr(input [14:0] a, input [7:0] d);
        @(posedge clk_i);
        a_o <= a;
        ce_n_o <= 1'b0;
        we_n_o <= 1'b0;
        dq_o <= d;
        @(posedge clk_i);
        we_n_o <= 1'b1;
        @(posedge clk_i);
        ce_n_o <= 1'b1;
        dq_o <= ~d;
    endtask

    // Read: address held for hold cycles, data taken at the second edge
    task rd(input [14:0] a, input integer hold, output [7:0] d, output oe);
        @(posedge clk_i);
        a_o <= a;
        ce_n_o <= 1'b0;
        oe_n_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        d = dq_i;
        oe = dq_oe_i;
        repeat (hold - 2) @(posedge clk_i);
        ce_n_o <= 1'b1;
        oe_n_o <= 1'b1;
        a_o <= ~a; // Moving away keeps an idle address from clearing flags
    endtask
endmodule

// ===== rwiu_top_checker.sv
// Checker for the watchdog and interrupt unit, bound to its top module.
// Assumes the synchronous active-low reset and the hand-over bus timing.
`timescale 1ns/1ps
`include "rwiu_map.vh"

module rwiu_top_checker (
    // Clock and reset
    input wire CLK_I,
    input wire RST_N_I,
    // Bus
    input wire [14:0] A_I,
    input wire CE_N_I,
    input wire OE_N_I,
    input wire WE_N_I,
    input wire [7:0] DQ_O,
    input wire DQ_OE_O,
    // Supply and pins
    input wire SUPPLY_FAIL_I,
    input wire INT_OE_O,
    input wire RST_OE_O,
    input wire DESELECT_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // ----
    // Assertions
    // ----
    rst_quiet_a: assert property ($rose(RST_N_I) |=> !INT_OE_O && !RST_OE_O && !DESELECT_O && !DQ_OE_O)
        else $error("outputs active after reset release");
    warn_delay_a: assert property ($rose(SUPPLY_FAIL_I) |=> !DESELECT_O [*8] ##[1:6] DESELECT_O)
        else $error("deselect not after the warning time");
    desel_hold_a: assert property (SUPPLY_FAIL_I && DESELECT_O |=> DESELECT_O)
        else $error("deselect dropped during supply failure");
    desel_end_a: assert property ($fell(SUPPLY_FAIL_I) |-> ##[0:2] !DESELECT_O)
        else $error("deselect held after supply recovery");
    desel_reset_a: assert property ($rose(DESELECT_O) |-> ##[0:1] RST_OE_O)
        else $error("no reset pulse with deselect");
    rst_pulse_a: assert property ($rose(RST_OE_O) |-> RST_OE_O [*8])
        else $error("reset pulse too short");
    rd_mapped_a: assert property (DQ_OE_O |-> $past(!CE_N_I && !OE_N_I && WE_N_I && A_I[14:3] == 12'hffe && A_I[2:0] != 3'h1))
        else $error("data driven without a mapped read");
    flags_freeze_a: assert property (DQ_OE_O && $past(DQ_OE_O) && $past(A_I) == `RWIU_ADDR_FLAGS && $past(A_I, 2) == `RWIU_ADDR_FLAGS |-> $stable(DQ_O))
        else $error("flags data changed during a held read");

    // Main scenarios reached
    cover property ($rose(DESELECT_O));
    cover property ($rose(RST_OE_O));
    cover property ($fell(INT_OE_O));
endmodule

bind rwiu_top rwiu_top_checker i_rwiu_top_checker (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .A_I(A_I), .CE_N_I(CE_N_I),
    .OE_N_I(OE_N_I), .WE_N_I(WE_N_I), .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O), .SUPPLY_FAIL_I(SUPPLY_FAIL_I),
    .INT_OE_O(INT_OE_O), .RST_OE_O(RST_OE_O), .DESELECT_O(DESELECT_O));

// ===== tb_rwiu_top.sv
// Testbench for the watchdog and interrupt unit.
// Assumes a 25 MHz oscillator parameter so one tick is four clocks.
`timescale 1ns/1ps
`include "rwiu_map.vh"

module tb_rwiu_top;
    localparam integer DIV = 4;
    reg clk = 1'b0;
    reg rst_n;
    reg [7:0] tsec, tmin, thour, tdate;
    reg tupd, sfail, blow;
    reg [7:0] rdat;
    reg roe;
    reg [3:0] m, r;
    wire [14:0] a;
    wire ce_n, oe_n, we_n, dq_oe, int_o, int_oe, rst_o, rst_oe, desel;
    wire [7:0] dqi, dqo;
    integer n_mismatch = 0, n_tests = 0, n, t0, p, k, cyc = 0;

    // 100 MHz clock and a cycle count for interval checks
    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    rwiu_top #(.OSC_HZ(32'd25000000), .RST_PULSE_CYC(32'd20), .WARN_CYC(32'd10)) i_rwiu_top (
        .CLK_I(clk), .RST_N_I(rst_n), .A_I(a), .CE_N_I(ce_n), .OE_N_I(oe_n), .WE_N_I(we_n), .DQ_I(dqi),
        .DQ_O(dqo), .DQ_OE_O(dq_oe), .TIME_SEC_I(tsec), .TIME_MIN_I(tmin), .TIME_HOUR_I(thour),
        .TIME_DATE_I(tdate), .TIME_UPDATE_I(tupd), .SUPPLY_FAIL_I(sfail), .BATTERY_LOW_I(blow),
        .INT_O(int_o), .INT_OE_O(int_oe), .RST_O(rst_o), .RST_OE_O(rst_oe), .DESELECT_O(desel));
    rwiu_cpu_model u_cpu (.clk_i(clk), .a_o(a), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .dq_o(dqi),
        .dq_i(dqo), .dq_oe_i(dq_oe));

    // ----
    // Checking tasks
    // ----
    task wrap_up;
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk8(input [7:0] got, input [7:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task chkr(input integer v, input integer lo, input integer hi);
        n_tests = n_tests + 1;
        if (v < lo || v > hi) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h expected %h to %h", $time, v, lo, hi);
        end
    endtask
    // Bounded wait on a pin; running out ends the run
    task wait_for(input integer sel, input lvl, input integer max);
        n = 0;
        while (((sel == 0) ? int_oe : (sel == 1) ? rst_oe : desel) !== lvl) begin
            if (n == max) begin
                chkr(n, 0, max - 1);
                wrap_up;
            end
            @(posedge clk);
            n = n + 1;
        end
    endtask
    task rdc(input [14:0] ad, input [7:0] exp);
        u_cpu.rd(ad, 8, rdat, roe);
        chk8(rdat, exp);
        chk8({7'h0, roe}, 8'h01);
    endtask
    task upd;
        @(posedge clk);
        tupd <= 1'b1;
        @(posedge clk);
        tupd <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // ----
    // Main sequence
    // ----
    initial begin
        rst_n <= 1'b0;
        {tsec, tmin, thour, tdate} <= 32'h31151205;
        tupd <= 1'b0;
        sfail <= 1'b0;
        blow <= 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`RWIU_ADDR_IRQ, 8'h00);
        rdc(`RWIU_ADDR_FLAGS, 8'h10);
        blow <= 1'b0;
        rdc(`RWIU_ADDR_FLAGS, 8'h00);
        // Rewrite restarts the count, then an unsteered time-out
        u_cpu.wr(`RWIU_ADDR_WDOG, 8'h04);
        repeat (6000) @(posedge clk);
        u_cpu.wr(`RWIU_ADDR_WDOG, 8'h04);
        wait_for(0, 1'b1, 8400);
        chkr(n, `RWIU_RES_16TH * DIV - 40, `RWIU_RES_16TH * DIV + 40);
        rdc(`RWIU_ADDR_FLAGS, 8'h80);
        chk8({7'h0, int_oe}, 8'h01);
        chk8({6'h0, int_o, rst_o}, 8'h00);
        u_cpu.wr(`RWIU_ADDR_WDOG, 8'h00);
        repeat (100) @(posedge clk);
        chk8({7'h0, int_oe}, 8'h00);
        // Steered time-out at quarter-second resolution
        u_cpu.wr(`RWIU_ADDR_WDOG, 8'h85);
        wait_for(1, 1'b1, 33000);
        chkr(n, `RWIU_RES_QUARTER * DIV - 40, `RWIU_RES_QUARTER * DIV + 40);
        chk8({7'h0, int_oe}, 8'h00);
        wait_for(1, 1'b0, 40);
        chkr(n, 18, 22);
        rdc(`RWIU_ADDR_WDOG, 8'h00);
        rdc(`RWIU_ADDR_FLAGS, 8'h80);
        // Periodic intervals, slowest first so no stale flag leaks on
        for (k = 0; k < 4; k = k + 1) begin
            r = 16'h2193 >> (12 - 4 * k);
            p = (r == 4'h1) ? `RWIU_P10MS_TICKS * DIV : (r == 4'h2) ? `RWIU_P100MS_TICKS * DIV : (1 << (r - 1)) * DIV;
            u_cpu.wr(`RWIU_ADDR_IRQ, {4'h1, r});
            wait_for(0, 1'b1, 14000);
            t0 = cyc;
            rdc(`RWIU_ADDR_FLAGS, 8'h08);
            wait_for(0, 1'b0, 20);
            wait_for(0, 1'b1, 14000);
            chkr(cyc - t0, p, p);
            rdc(`RWIU_ADDR_FLAGS, 8'h08);
        end
        // Let one more fast event land first, so the flag below is certain
        repeat (20) @(posedge clk);
        u_cpu.wr(`RWIU_ADDR_IRQ, 8'h10);
        rdc(`RWIU_ADDR_FLAGS, 8'h08);
        repeat (1400) @(posedge clk);
        rdc(`RWIU_ADDR_FLAGS, 8'h00);
        // Alarm masks from all fields down to a full date match
        for (k = 0; k < 5; k = k + 1) begin
            m = 20'hfec80 >> (16 - 4 * k);
            u_cpu.wr(`RWIU_ADDR_ALM_SEC, {m[0], 7'h30});
            u_cpu.wr(`RWIU_ADDR_ALM_MIN, {m[1], 7'h15});
            u_cpu.wr(`RWIU_ADDR_ALM_HOUR, {m[2], 7'h12});
            u_cpu.wr(`RWIU_ADDR_ALM_DATE, {m[3], 7'h05});
            tsec <= m[0] ? 8'h59 : 8'h30;
            tmin <= m[1] ? 8'h59 : 8'h15;
            thour <= m[2] ? 8'h23 : 8'h12;
            tdate <= m[3] ? 8'h28 : 8'h05;
            upd;
            chk8({7'h0, int_oe}, 8'h00);
            rdc(`RWIU_ADDR_FLAGS, 8'h40);
        end
        tsec <= 8'h31;
        upd;
        rdc(`RWIU_ADDR_FLAGS, 8'h00);
        u_cpu.wr(`RWIU_ADDR_IRQ, 8'h80);
        tsec <= 8'h30;
        upd;
        wait_for(0, 1'b1, 5);
        rdc(`RWIU_ADDR_FLAGS, 8'h40);
        chk8({7'h0, int_oe}, 8'h00);
        // Supply failure with backup alarm enabled
        u_cpu.wr(`RWIU_ADDR_WDOG, 8'h04);
        u_cpu.wr(`RWIU_ADDR_IRQ, 8'he0);
        @(posedge clk);
        sfail <= 1'b1;
        t0 = cyc;
        wait_for(0, 1'b1, 5);
        wait_for(2, 1'b1, 20);
        chkr(cyc - t0, 9, 13);
        repeat (2) @(posedge clk);
        chk8({6'h0, int_oe, rst_oe}, 8'h01);
        upd;
        wait_for(0, 1'b1, 5);
        sfail <= 1'b0;
        wait_for(1, 1'b0, 60);
        rdc(`RWIU_ADDR_IRQ, 8'h00);
        rdc(`RWIU_ADDR_WDOG, 8'h00);
        rdc(`RWIU_ADDR_FLAGS, 8'h60);
        rdc(`RWIU_ADDR_ALM_DATE, 8'h05);
        wrap_up;
    end
endmodule
